// *** hw/alert_source_mask_bank.sv ***
// Alert mask bank: per phased class mask registers reached through the shared mask command.
// Function
// - Mask bit zero passes alert, one blocks it
// - Write word updates; process call reads one byte
// - Low byte selects class, high byte masks
// - Masking never stops status bits being set
// - Output current class uses code 7Bh
// - Output current bits 7,5,4 writable, others zero
// - Input class 7Ch, only bit 3 writable
// - Temperature class 7Dh, bits 7,6 writable
// - Temperature bits 5:0 always read zero
// - Communication logic class uses code 7Eh
// - Communication bits 7,6,5,4,1 writable, bit0 zero
// - Other class 7Fh, independent of phase
// - Phased classes need phase set to FFh
module alert_source_mask_bank
    import alert_mask_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    alert_mask_if.device bus,
    input wire logic [7:0] phase_i,
    input wire logic nvm_load_i,
    input wire logic [31:0] nvm_masks_i,
    input wire logic [7:0] output_current_status_i,
    input wire logic [7:0] input_status_i,
    input wire logic [7:0] temperature_status_i,
    input wire logic [7:0] comm_logic_status_i,
    input wire logic [7:0] miscellaneous_status_i,
    output logic [31:0] masks_o,
    output logic alert_request_o
);
    localparam logic [31:0] WMASK_ALL = {COMM_LOGIC_WMASK, TEMPERATURE_WMASK,
                                         INPUT_WMASK, OUTPUT_CURRENT_WMASK};
    localparam logic [2:0] IDX_OTHER = 3'h4;
    localparam logic [2:0] IDX_NONE = 3'h7;

    logic [7:0] mask_r [NUM_CLASSES];
    logic [7:0] mask_nxt [NUM_CLASSES];
    logic [NUM_CLASSES-1:0] wr_en;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic bad_r;
    logic bad_nxt;
    logic alert_r;
    logic alert_nxt;
    logic [2:0] cls;
    logic [1:0] idx;
    logic cmd_ok;
    logic cls_ok;
    logic phase_ok;
    logic take;
    logic take_write;
    logic take_read;
    logic refuse;
    logic [7:0] status_v [NUM_CLASSES];
    logic [7:0] pass_v [NUM_CLASSES];
    logic [NUM_CLASSES-1:0] class_alert;
    logic other_alert;
    logic mask_overcurrent_fault;
    logic mask_overcurrent_warning;
    logic mask_undercurrent_fault;
    logic mask_low_input_voltage;
    logic mask_overtemp_fault;
    logic mask_overtemp_warning;
    logic mask_invalid_command;
    logic mask_invalid_data;
    logic mask_packet_check_fail;
    logic mask_memory_fault;
    logic mask_other_comm_fault;

    // Class decode of the selector byte.
    always_comb begin
        case (bus.data_lo)
            CLASS_OUTPUT_CURRENT: cls = 3'h0;
            CLASS_INPUT: cls = 3'h1;
            CLASS_TEMPERATURE: cls = 3'h2;
            CLASS_COMM_LOGIC: cls = 3'h3;
            CLASS_OTHER: cls = IDX_OTHER;
            default: cls = IDX_NONE;
        endcase
    end

    assign idx = cls[1:0];

    // Acceptance of a request; a load from backup takes precedence and drops it.
    always_comb begin
        cmd_ok = (bus.cmd == ALERT_SOURCE_MASK_CMD);
        cls_ok = (cls != IDX_NONE);
        phase_ok = (cls == IDX_OTHER) || (phase_i == PHASE_ALL);
        take = bus.req && !nvm_load_i && cmd_ok && cls_ok && phase_ok;
        take_write = take && (bus.op == OP_WRITE_WORD);
        take_read = take && (bus.op == OP_PROCESS_CALL);
        refuse = bus.req && !nvm_load_i && !take_write && !take_read;
    end

    // One mask register per phased class; the other class has no storage.
    for (genvar g = 0; g < NUM_CLASSES; g++) begin : g_class
        assign wr_en[g] = take_write && (cls == 3'(g));

        always_comb begin
            mask_nxt[g] = mask_r[g];
            if (nvm_load_i) begin
                mask_nxt[g] = nvm_masks_i[8*g +: 8] & WMASK_ALL[8*g +: 8];
            end else if (wr_en[g]) begin
                mask_nxt[g] = bus.data_hi & WMASK_ALL[8*g +: 8];
            end
        end

        always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                mask_r[g] <= BYTE_RESET;
            end else begin
                mask_r[g] <= mask_nxt[g];
            end
        end

        assign masks_o[8*g +: 8] = mask_r[g];
        assign class_alert[g] = |(status_v[g] & pass_v[g]);
    end

    // Named mask bits of the supported conditions.
    assign mask_overcurrent_fault = mask_r[0][MASK_OVERCURRENT_FAULT];
    assign mask_overcurrent_warning = mask_r[0][MASK_OVERCURRENT_WARNING];
    assign mask_undercurrent_fault = mask_r[0][MASK_UNDERCURRENT_FAULT];
    assign mask_low_input_voltage = mask_r[1][MASK_LOW_INPUT_VOLTAGE];
    assign mask_overtemp_fault = mask_r[2][MASK_OVERTEMP_FAULT];
    assign mask_overtemp_warning = mask_r[2][MASK_OVERTEMP_WARNING];
    assign mask_invalid_command = mask_r[3][MASK_INVALID_COMMAND];
    assign mask_invalid_data = mask_r[3][MASK_INVALID_DATA];
    assign mask_packet_check_fail = mask_r[3][MASK_PACKET_CHECK_FAIL];
    assign mask_memory_fault = mask_r[3][MASK_MEMORY_FAULT];
    assign mask_other_comm_fault = mask_r[3][MASK_OTHER_COMM_FAULT];

    // A condition reaches the alert only through a supported, cleared mask bit.
    always_comb begin
        for (int i = 0; i < NUM_CLASSES; i++) begin
            pass_v[i] = 8'h00;
        end
        pass_v[0][MASK_OVERCURRENT_FAULT] = !mask_overcurrent_fault;
        pass_v[0][MASK_OVERCURRENT_WARNING] = !mask_overcurrent_warning;
        pass_v[0][MASK_UNDERCURRENT_FAULT] = !mask_undercurrent_fault;
        pass_v[1][MASK_LOW_INPUT_VOLTAGE] = !mask_low_input_voltage;
        pass_v[2][MASK_OVERTEMP_FAULT] = !mask_overtemp_fault;
        pass_v[2][MASK_OVERTEMP_WARNING] = !mask_overtemp_warning;
        pass_v[3][MASK_INVALID_COMMAND] = !mask_invalid_command;
        pass_v[3][MASK_INVALID_DATA] = !mask_invalid_data;
        pass_v[3][MASK_PACKET_CHECK_FAIL] = !mask_packet_check_fail;
        pass_v[3][MASK_MEMORY_FAULT] = !mask_memory_fault;
        pass_v[3][MASK_OTHER_COMM_FAULT] = !mask_other_comm_fault;
    end

    // Status inputs are only read here; masking never alters them.
    assign status_v[0] = output_current_status_i;
    assign status_v[1] = input_status_i;
    assign status_v[2] = temperature_status_i;
    assign status_v[3] = comm_logic_status_i;
    // The other class is hard-masked, so its status never raises the alert.
    assign other_alert = |(miscellaneous_status_i & OTHER_SUPPORTED & ~OTHER_VALUE);

    // Read answers and refusals, each a one-cycle pulse.
    always_comb begin
        rdata_nxt = rdata_r;
        rvalid_nxt = take_read;
        bad_nxt = refuse;
        if (take_read) begin
            if (cls == IDX_OTHER) begin
                rdata_nxt = OTHER_VALUE;
            end else begin
                rdata_nxt = mask_r[idx] & WMASK_ALL[8*idx +: 8];
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_r <= BYTE_RESET;
            rvalid_r <= 1'b0;
            bad_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            bad_r <= bad_nxt;
        end
    end

    // The alert request is registered so that it changes only on the clock.
    always_comb begin
        alert_nxt = (|class_alert) | other_alert;
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            alert_r <= 1'b0;
        end else begin
            alert_r <= alert_nxt;
        end
    end

    // Acknowledge follows the request in the same cycle.
    assign bus.ack = bus.req;
    assign bus.rdata = rdata_r;
    assign bus.rvalid = rvalid_r;
    assign bus.bad = bad_r;
    assign alert_request_o = alert_r;
endmodule : alert_source_mask_bank

// *** shared/alert_mask_pkg.sv ***
// Package with command codes, class selectors, field layouts and handshake types of the mask bank.
package alert_mask_pkg;
    localparam logic [7:0] ALERT_SOURCE_MASK_CMD = 8'h1b;
    localparam logic [7:0] CLASS_OUTPUT_CURRENT = 8'h7b;
    localparam logic [7:0] CLASS_INPUT = 8'h7c;
    localparam logic [7:0] CLASS_TEMPERATURE = 8'h7d;
    localparam logic [7:0] CLASS_COMM_LOGIC = 8'h7e;
    localparam logic [7:0] CLASS_OTHER = 8'h7f;
    localparam logic [7:0] PHASE_ALL = 8'hff;
    localparam logic [7:0] OUTPUT_CURRENT_WMASK = 8'hb0;
    localparam logic [7:0] INPUT_WMASK = 8'h08;
    localparam logic [7:0] TEMPERATURE_WMASK = 8'hc0;
    localparam logic [7:0] COMM_LOGIC_WMASK = 8'hf2;
    localparam logic [7:0] OTHER_VALUE = 8'h01;
    localparam logic [7:0] OTHER_SUPPORTED = 8'h01;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam int MASK_OVERCURRENT_FAULT = 7;
    localparam int MASK_OVERCURRENT_WARNING = 5;
    localparam int MASK_UNDERCURRENT_FAULT = 4;
    localparam int MASK_LOW_INPUT_VOLTAGE = 3;
    localparam int MASK_OVERTEMP_FAULT = 7;
    localparam int MASK_OVERTEMP_WARNING = 6;
    localparam int MASK_INVALID_COMMAND = 7;
    localparam int MASK_INVALID_DATA = 6;
    localparam int MASK_PACKET_CHECK_FAIL = 5;
    localparam int MASK_MEMORY_FAULT = 4;
    localparam int MASK_OTHER_COMM_FAULT = 1;
    localparam int NUM_CLASSES = 4;
    localparam logic [1:0] OP_WRITE_WORD = 2'h1;
    localparam logic [1:0] OP_PROCESS_CALL = 2'h2;
    typedef enum logic [1:0] {
        HOST_IDLE = 2'b00,
        HOST_REQ = 2'b01,
        HOST_WAIT = 2'b11
    } host_state_e;
endpackage : alert_mask_pkg

// *** shared/alert_mask_if.sv ***
// Interface joining the host end and the mask bank over the shared mask command.
interface alert_mask_if;
    logic req;
    logic [1:0] op;
    logic [7:0] cmd;
    logic [7:0] data_lo;
    logic [7:0] data_hi;
    logic ack;
    logic [7:0] rdata;
    logic rvalid;
    logic bad;
    modport device (input req, input op, input cmd, input data_lo, input data_hi,
                    output ack, output rdata, output rvalid, output bad);
    modport host (output req, output op, output cmd, output data_lo, output data_hi,
                  input ack, input rdata, input rvalid, input bad);
endinterface : alert_mask_if

// *** hw/alert_mask_host.sv ***
// Host end: issues mask writes and process call reads on the shared mask command.
module alert_mask_host
    import alert_mask_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    alert_mask_if.host bus,
    input wire logic start_i,
    input wire logic is_read_i,
    input wire logic [7:0] class_i,
    input wire logic [7:0] value_i,
    output logic busy_o,
    output logic done_o,
    output logic error_o,
    output logic [7:0] rdata_o
);
    host_state_e state_r, state_nxt;
    logic is_read_r, is_read_nxt;
    logic [7:0] class_r, class_nxt, value_r, value_nxt, rdata_r, rdata_nxt;
    logic done_r, done_nxt, error_r, error_nxt;

    always_comb begin
        state_nxt = state_r;
        is_read_nxt = is_read_r;
        class_nxt = class_r;
        value_nxt = value_r;
        rdata_nxt = rdata_r;
        done_nxt = 1'b0;
        error_nxt = 1'b0;
        case (state_r)
            HOST_IDLE: begin
                if (start_i) begin
                    is_read_nxt = is_read_i;
                    class_nxt = class_i;
                    value_nxt = value_i;
                    state_nxt = HOST_REQ;
                end
            end
            HOST_REQ: begin
                state_nxt = HOST_WAIT;
            end
            HOST_WAIT: begin
                done_nxt = 1'b1;
                error_nxt = bus.bad;
                if (bus.rvalid) begin
                    rdata_nxt = bus.rdata;
                end
                state_nxt = HOST_IDLE;
            end
            default: state_nxt = HOST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= HOST_IDLE;
            is_read_r <= 1'b0;
            class_r <= BYTE_RESET;
            value_r <= BYTE_RESET;
            rdata_r <= BYTE_RESET;
            done_r <= 1'b0;
            error_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            is_read_r <= is_read_nxt;
            class_r <= class_nxt;
            value_r <= value_nxt;
            rdata_r <= rdata_nxt;
            done_r <= done_nxt;
            error_r <= error_nxt;
        end
    end

    assign bus.req = (state_r == HOST_REQ);
    assign bus.op = is_read_r ? OP_PROCESS_CALL : OP_WRITE_WORD;
    assign bus.cmd = ALERT_SOURCE_MASK_CMD;
    assign bus.data_lo = class_r;
    assign bus.data_hi = is_read_r ? 8'h00 : value_r;
    assign busy_o = (state_r != HOST_IDLE);
    assign done_o = done_r;
    assign error_o = error_r;
    assign rdata_o = rdata_r;
endmodule : alert_mask_host

// *** dv/alert_mask_chk.sv ***
// Checker of the mask command handshake between the host end and the mask bank.
module alert_mask_chk
    import alert_mask_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic req,
    input wire logic [1:0] op,
    input wire logic [7:0] cmd,
    input wire logic [7:0] data_lo,
    input wire logic [7:0] data_hi,
    input wire logic ack,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire logic bad
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    wire logic rd = req && op == OP_PROCESS_CALL && cmd == ALERT_SOURCE_MASK_CMD;
    property p_ack; ack == req; endproperty
    a_ack: assert property (p_ack) else $error("ack differs from req");
    property p_rval; rvalid |-> $past(req) && $past(op) == OP_PROCESS_CALL && !bad; endproperty
    a_rval: assert property (p_rval) else $error("read byte without a read");
    property p_bad; bad |-> $past(req) && !rvalid; endproperty
    a_bad: assert property (p_bad) else $error("refusal without a request");
    property p_wr; req && op == OP_WRITE_WORD |=> !rvalid; endproperty
    a_wr: assert property (p_wr) else $error("write returned a read byte");
    property p_cur; rd && data_lo == CLASS_OUTPUT_CURRENT |=> !rvalid || (rdata & 8'h4f) == 8'h00;
    endproperty
    a_cur: assert property (p_cur) else $error("current class bits 6,3:0 set");
    property p_in; rd && data_lo == CLASS_INPUT |=> !rvalid || (rdata & 8'hf7) == 8'h00;
    endproperty
    a_in: assert property (p_in) else $error("input class has extra bits");
    property p_tmp; rd && data_lo == CLASS_TEMPERATURE |=> !rvalid || rdata[5:0] == 6'h00;
    endproperty
    a_tmp: assert property (p_tmp) else $error("temperature bits 5:0 set");
    property p_cml; rd && data_lo == CLASS_COMM_LOGIC |=> !rvalid || (rdata & 8'h0d) == 8'h00;
    endproperty
    a_cml: assert property (p_cml) else $error("comm class bits 3,2,0 set");
    property p_oth; rd && data_lo == CLASS_OTHER |=> !bad && (!rvalid || rdata == 8'h01);
    endproperty
    a_oth: assert property (p_oth) else $error("other class read wrong");
endmodule : alert_mask_chk

// *** dv/tb_top.sv ***
// Self-checking bench joining the host end and the mask bank.
module tb_top
    import alert_mask_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic start = 1'b0, is_read = 1'b0, nvm_load = 1'b0, busy, done, error, alert;
    logic [7:0] cls = 8'h00, val = 8'h00, phase = 8'hff, rdata;
    logic [7:0] st [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [31:0] nvm = 32'h0, masks, r, seed = 32'h9f6a5c68;
    int miscompares = 0;
    int checked = 0;
    logic [7:0] m [4];
    logic [7:0] wm [4] = '{OUTPUT_CURRENT_WMASK, INPUT_WMASK, TEMPERATURE_WMASK, COMM_LOGIC_WMASK};
    logic [7:0] codes [6] = '{CLASS_OUTPUT_CURRENT, CLASS_INPUT, CLASS_TEMPERATURE,
        CLASS_COMM_LOGIC, CLASS_OTHER, 8'h80};
    always #20 sys_clk_i = ~sys_clk_i;
    alert_mask_if bus_if();
    alert_source_mask_bank alert_source_mask_bank_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .bus(bus_if), .phase_i(phase), .nvm_load_i(nvm_load), .nvm_masks_i(nvm),
        .output_current_status_i(st[0]), .input_status_i(st[1]), .temperature_status_i(st[2]),
        .comm_logic_status_i(st[3]), .miscellaneous_status_i(st[4]), .masks_o(masks),
        .alert_request_o(alert));
    alert_mask_host alert_mask_host_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .bus(bus_if),
        .start_i(start), .is_read_i(is_read), .class_i(cls), .value_i(val), .busy_o(busy),
        .done_o(done), .error_o(error), .rdata_o(rdata));
    alert_mask_chk alert_mask_chk_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .req(bus_if.req),
        .op(bus_if.op), .cmd(bus_if.cmd), .data_lo(bus_if.data_lo), .data_hi(bus_if.data_hi),
        .ack(bus_if.ack), .rdata(bus_if.rdata), .rvalid(bus_if.rvalid), .bad(bus_if.bad));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [31:0] want_alert();
        logic a;
        a = 1'b0;
        for (int c = 0; c < 4; c++)
            a = a | (|(st[c] & wm[c] & ~m[c]));
        return {31'h0, a};
    endfunction : want_alert
    task automatic end_of_test();
        $display("compared %0d, mismatched %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic run_op(input logic rd, input int k, input logic [7:0] v, input logic [7:0] ph);
        logic err;
        err = (k == 5) || (k < 4 && ph !== PHASE_ALL);
        @(posedge sys_clk_i);
        start <= 1'b1;
        is_read <= rd;
        cls <= codes[k];
        val <= v;
        phase <= ph;
        for (int i = 0; i < 5; i++)
            st[i] <= (i == 4) ? {7'h00, 1'(rnd())} : 8'(rnd());
        @(posedge sys_clk_i);
        start <= 1'b0;
        @(negedge sys_clk_i);
        cmp({31'h0, busy}, 32'h1);
        for (int i = 0; i < 10 && done !== 1'b1; i++)
            @(negedge sys_clk_i);
        cmp({31'h0, done}, 32'h1);
        cmp({31'h0, busy}, 32'h0);
        cmp({31'h0, error}, {31'h0, err});
        if (!err && !rd && k < 4)
            m[k] = v & wm[k];
        if (!err && rd)
            cmp({24'h0, rdata}, {24'h0, (k == 4) ? OTHER_VALUE : m[k]});
        cmp(masks, {m[3], m[2], m[1], m[0]});
        cmp({31'h0, alert}, want_alert());
    endtask : run_op
    initial begin
        repeat (10) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        @(negedge sys_clk_i);
        cmp(masks, 32'h0);
        cmp({31'h0, alert}, 32'h0);
        cmp({31'h0, busy}, 32'h0);
        @(posedge sys_clk_i);
        for (int c = 0; c < 4; c++)
            m[c] = 8'(rnd()) & wm[c];
        nvm <= {m[3], m[2], m[1], m[0]};
        nvm_load <= 1'b1;
        @(posedge sys_clk_i);
        nvm_load <= 1'b0;
        @(negedge sys_clk_i);
        cmp(masks, {m[3], m[2], m[1], m[0]});
        for (int v = 0; v < 2; v++)
            for (int k = 0; k < 12; k++)
                run_op(k[0], k / 2, v ? 8'h00 : 8'hff, PHASE_ALL);
        repeat (80) begin
            r = rnd();
            run_op(r[0], int'(r[10:8]) % 6, r[23:16],
                   r[2:1] == 2'b00 ? {1'b0, r[30:24]} : PHASE_ALL);
        end
        end_of_test();
    end
    initial begin
        #100us;
        miscompares++;
        end_of_test();
    end
endmodule : tb_top
